// *** verilog/supply_mon_pkg.sv ***
package supply_mon_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int CLOCK_HZ              = 20000000;
  localparam int REF_FILTER_NS         = 9000;   // reference anti-glitch time
  localparam int POR_MIN_LOW_NS        = 361;    // least time below lockout
  localparam int POR_MAX_DELAY_NS      = 1500;   // longest assertion delay
  localparam int OV_MAX_SWITCH_NS      = 1000;   // longest overvoltage switch time
  localparam int UV_FILTER_MIN_NS      = 800;
  localparam int UV_FILTER_MAX_NS      = 2000;
  localparam int NS_PER_S              = 1000000000;
  // Least times round up, longest times round down
  localparam int REF_FILTER_CYC = (REF_FILTER_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int POR_MIN_CYC    = (POR_MIN_LOW_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int POR_MAX_CYC    = (POR_MAX_DELAY_NS * (CLOCK_HZ / 1000000)) / 1000;
  localparam int OV_MAX_CYC     = (OV_MAX_SWITCH_NS * (CLOCK_HZ / 1000000)) / 1000;
  localparam int UV_FILTER_CYC  = (UV_FILTER_MIN_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
  localparam int UV_FILTER_MAX_CYC = (UV_FILTER_MAX_NS * (CLOCK_HZ / 1000000)) / 1000;
  // ==========================================================================
  // Register map
  localparam logic [9:0]  ADDR_IRQ_CONFIG    = 10'h1C5;
  localparam logic [9:0]  ADDR_HEALTH_FLAGS  = 10'h1D2;
  localparam logic [9:0]  ADDR_PART_IDENT    = 10'h1D5;
  localparam logic [15:0] IRQ_CONFIG_RESET   = 16'h0000;
  localparam logic [15:0] PART_IDENT_VALUE   = 16'h5A31; // Arbitrary value
  localparam int          BIT_UV_MAIN        = 0;  // Flag and enable position
  localparam int          BIT_OV_MAIN        = 1;
  localparam int          BIT_OV_GATE        = 2;
  // ==========================================================================
  // Serial frame
  localparam logic [7:0]  CTRL_PATTERN       = 8'hA8;
  localparam logic [15:0] READ_IN_RESET      = 16'h0000;
  localparam int          FRAME_BITS         = 32;
endpackage : supply_mon_pkg

// *** verilog/glitch_filter.sv ***
`timescale 1ns/1ps
// ============================================================================
// Level filter: output follows input once input is stable for CYCLES clocks
module glitch_filter #(
  parameter int CYCLES = 4
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic raw,
  output logic      filtered_q
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] count_q;

  // Counter restarts whenever input matches output, so a glitch never passes
  always_ff @(posedge clock) begin
    if (rst) begin
      count_q    <= '0;
      filtered_q <= 1'b0;
    end else if (raw == filtered_q) begin
      count_q <= '0;
    end else if (count_q == W'(CYCLES - 1)) begin
      count_q    <= '0;
      filtered_q <= raw;
    end else begin
      count_q <= count_q + W'(1);
    end
  end
endmodule : glitch_filter

// *** verilog/core_reset_and_supply_monitor.sv ***
`timescale 1ns/1ps
// Functional notes
// - Core regulator stays off until reference is stable, then starts.
// - Reference stable asserts only after settling plus 9.0 us filter.
// - Power-on reset asserts after core supply low 361 ns, within 1.5 us.
// - Core reset is AND of power-on, pin and soft reset lows.
// - Serial module is inactive whenever core reset is asserted.
// - Outside reset, command word answer on MISO is 0xA8.
// - Register reads during reset return 0x00.
// - Core and serial link work with only main 5 V present.
// - Main supply overvoltage disconnects loads within 1.0 us, reconnects after.
// - Gate-supply shutdown threshold exceeded turns off gate regulator.
// - Pre-drivers disabled while main or gate undervoltage active.
// - Main undervoltage sets flag in health flags register 0x1D2.
// - Interrupt raised on main undervoltage if enabled at 0x1C5.
// - Main undervoltage comparator filtered 0.8 to 2.0 us first.
module core_reset_and_supply_monitor
  import supply_mon_pkg::*;
#(
  parameter int REF_CYC = REF_FILTER_CYC
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic bandgap_settled,
  input  wire logic core_supply_low,
  input  wire logic reset_pin_n,
  input  wire logic main_ov_cmp,
  input  wire logic gate_shutdown_cmp,
  input  wire logic main_uv_cmp,
  input  wire logic gate_supply_undervoltage,
  input  wire logic spi_sck,
  input  wire logic spi_cs_n,
  input  wire logic spi_mosi,
  output logic      spi_miso,
  output logic      spi_miso_oe,
  output logic      reference_stable,
  output logic      core_regulator_en,
  output logic      power_on_reset_n,
  output logic      core_reset_n,
  output logic      main_load_connect,
  output logic      gate_regulator_en,
  output logic      predriver_enable,
  output logic      main_supply_undervoltage,
  output logic      irq_n
);
  // ==========================================================================
  // Input synchronisers: every pin passes two flops
  localparam int NSYNC = 10;
  // Idle levels: reset pin high, gate supply fault high, chip select high,
  // so neither a false edge nor a false overvoltage follows reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 10'h08A;
  logic [NSYNC-1:0] raw_in, s1_q, s2_q;
  assign raw_in = {bandgap_settled, core_supply_low, reset_pin_n, main_ov_cmp,
                   gate_shutdown_cmp, main_uv_cmp, gate_supply_undervoltage,
                   spi_sck, spi_cs_n, spi_mosi};
  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
    end
  end
  logic bg_s, csl_s, rpin_s, ov_s, gsd_s, uv_s, guv_s, sck_s, cs_s, mosi_s;
  assign {bg_s, csl_s, rpin_s, ov_s, gsd_s, uv_s, guv_s, sck_s, cs_s, mosi_s} = s2_q;

  // ==========================================================================
  // Reference filter and core regulator
  logic ref_f;
  glitch_filter #(.CYCLES(REF_CYC)) u_ref_filter (
    .clock      (clock),
    .rst        (rst),
    .raw        (bg_s),
    .filtered_q (ref_f)
  );
  // Reference flag follows the filtered bandgap state
  always_ff @(posedge clock) begin
    if (rst) begin
      reference_stable <= 1'b0;
    end else begin
      reference_stable <= ref_f;
    end
  end

  // Regulator enable shares the filtered source, so it can never lead the
  // reference flag by a cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      core_regulator_en <= 1'b0;
    end else begin
      core_regulator_en <= ref_f;  // Starts only with reference held
    end
  end

  // ==========================================================================
  // Power-on reset: low must persist the least time; sync delay keeps well
  // inside the longest assertion delay
  localparam int PW = $clog2(POR_MIN_CYC + 1);
  logic [PW-1:0] por_cnt_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      por_cnt_q        <= '0;
      power_on_reset_n <= 1'b0;
    end else if (!core_regulator_en || !csl_s) begin
      por_cnt_q        <= '0;
      power_on_reset_n <= core_regulator_en;
    end else if (por_cnt_q == PW'(POR_MIN_CYC - 1)) begin
      power_on_reset_n <= 1'b0;
    end else begin
      por_cnt_q <= por_cnt_q + PW'(1);
    end
  end

  // ==========================================================================
  // Core reset: combined AND, raised at once, released through two flops
  logic soft_reset_n_q;
  logic comb_reset_n;
  logic [1:0] rel_q;
  assign comb_reset_n = power_on_reset_n & rpin_s & soft_reset_n_q;
  always_ff @(posedge clock) begin
    if (rst || !comb_reset_n) begin
      rel_q <= 2'h0;               // Assert without waiting
    end else begin
      rel_q <= {rel_q[0], 1'b1};   // Release on a common edge
    end
  end
  // Any low source pulls the core reset on the next edge; release waits for
  // the two-stage count so every module leaves reset together
  always_ff @(posedge clock) begin
    if (rst) begin
      core_reset_n <= 1'b0;
    end else begin
      core_reset_n <= comb_reset_n & rel_q[1];
    end
  end

  // ==========================================================================
  // Supply monitors; load switch and undervoltage flag run from main supply state alone
  logic uv_f;
  glitch_filter #(.CYCLES(UV_FILTER_CYC)) u_uv_filter (
    .clock      (clock),
    .rst        (rst),
    .raw        (uv_s),
    .filtered_q (uv_f)
  );
  // Overvoltage cut: only the sync delay stands between comparator and
  // switch, about three clocks against a one microsecond limit
  always_ff @(posedge clock) begin
    if (rst) begin
      main_load_connect <= 1'b0;
    end else begin
      main_load_connect <= !ov_s;
    end
  end

  // Gate regulator: off above the shutdown threshold and while the pin or
  // the power-on reset holds the device
  always_ff @(posedge clock) begin
    if (rst) begin
      gate_regulator_en <= 1'b0;
    end else begin
      gate_regulator_en <= !gsd_s && power_on_reset_n && rpin_s;
    end
  end

  // Undervoltage indication starts high so nothing trusts the supply early
  always_ff @(posedge clock) begin
    if (rst) begin
      main_supply_undervoltage <= 1'b1;
    end else begin
      main_supply_undervoltage <= uv_f;
    end
  end

  // Pre-drivers need both supplies good and the core out of reset
  always_ff @(posedge clock) begin
    if (rst) begin
      predriver_enable <= 1'b0;
    end else begin
      predriver_enable <= !uv_f && !guv_s && core_reset_n;
    end
  end

  // ==========================================================================
  // Registers: enable config and sticky health flags, cleared by reading
  logic [15:0] irq_cfg_q, flags_q, flags_set;
  logic        uv_prev_q, rd_flags_pulse, wr_cfg_pulse;
  logic [15:0] wr_data;
  assign flags_set = 16'(({15'h0, uv_f && !uv_prev_q} << BIT_UV_MAIN) |
                         ({15'h0, ov_s} << BIT_OV_MAIN) |
                         ({15'h0, gsd_s} << BIT_OV_GATE));
  // Previous filtered state, for the rising-edge flag event
  always_ff @(posedge clock) begin
    if (rst || !core_reset_n) begin
      uv_prev_q <= 1'b0;
    end else begin
      uv_prev_q <= uv_f;
    end
  end

  // Interrupt enables; cleared with every core reset
  always_ff @(posedge clock) begin
    if (rst || !core_reset_n) begin
      irq_cfg_q <= IRQ_CONFIG_RESET;
    end else if (wr_cfg_pulse) begin
      irq_cfg_q <= wr_data;
    end
  end

  // Set wins over read clear so no event is lost; the clear takes the same
  // edge on which the old value is loaded for shifting out
  always_ff @(posedge clock) begin
    if (rst || !core_reset_n) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= (rd_flags_pulse ? 16'h0000 : flags_q) | flags_set;
    end
  end

  // Level request: stays low until the flag is read or its enable cleared
  always_ff @(posedge clock) begin
    if (rst) begin
      irq_n <= 1'b1;
    end else begin
      irq_n <= !(|(flags_q & irq_cfg_q)) || !core_reset_n;
    end
  end

  // ==========================================================================
  // Serial slave, mode 0: 16-bit command (bit15 read, addr [9:0]), 16 data
  function automatic logic [15:0] reg_read(input logic [9:0] a);
    unique case (a)
      ADDR_IRQ_CONFIG:   reg_read = irq_cfg_q;
      ADDR_HEALTH_FLAGS: reg_read = flags_q;
      ADDR_PART_IDENT:   reg_read = PART_IDENT_VALUE;
      default:           reg_read = 16'h0000;
    endcase
  endfunction : reg_read

  logic        sck_prev_q, cs_prev_q;
  logic [5:0]  bit_cnt_q;
  logic [15:0] sh_in_q, cmd_q, sh_out_q;
  logic        spi_live;
  logic        rise, fall, cs_fall;
  assign spi_live = core_reset_n;           // Inactive during reset
  assign rise     = sck_s && !sck_prev_q && !cs_s;
  assign fall     = !sck_s && sck_prev_q && !cs_s;
  assign cs_fall  = !cs_s && cs_prev_q;
  assign wr_data  = {sh_in_q[14:0], mosi_s};
  assign wr_cfg_pulse   = spi_live && rise && bit_cnt_q == 6'(FRAME_BITS - 1) &&
                          !cmd_q[15] && cmd_q[9:0] == ADDR_IRQ_CONFIG;
  // Clear on the fall that loads the flags for shifting out, so the host
  // always sees what was cleared
  assign rd_flags_pulse = spi_live && fall && bit_cnt_q == 6'(FRAME_BITS / 2) &&
                          cmd_q[15] && cmd_q[9:0] == ADDR_HEALTH_FLAGS;

  always_ff @(posedge clock) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  // Reset answer shows as zeros: no pattern, no data
  always_ff @(posedge clock) begin
    if (rst || !spi_live || cs_s) begin
      bit_cnt_q <= '0;
      sh_in_q   <= 16'h0000;
      cmd_q     <= 16'h0000;
      sh_out_q  <= spi_live ? {CTRL_PATTERN, 8'h00} : READ_IN_RESET;
    end else begin
      if (rise) begin
        sh_in_q   <= wr_data;
        bit_cnt_q <= bit_cnt_q + 6'h01;
        if (bit_cnt_q == 6'(FRAME_BITS / 2 - 1)) begin
          cmd_q <= wr_data;
        end
      end
      if (fall) begin
        if (bit_cnt_q == 6'(FRAME_BITS / 2)) begin
          sh_out_q <= cmd_q[15] ? reg_read(cmd_q[9:0]) : 16'h0000;
        end else begin
          sh_out_q <= {sh_out_q[14:0], 1'b0};
        end
      end
    end
  end
  always_ff @(posedge clock) begin
    if (rst) begin
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso    <= sh_out_q[15];          // Pattern in command word
      spi_miso_oe <= !cs_s && !cs_fall;
    end
  end

  // Soft reset: write of 0xFFFF to part ident address pulses soft reset low
  always_ff @(posedge clock) begin
    if (rst) begin
      soft_reset_n_q <= 1'b1;
    end else begin
      soft_reset_n_q <= !(spi_live && rise && bit_cnt_q == 6'(FRAME_BITS - 1) &&
                          !cmd_q[15] && cmd_q[9:0] == ADDR_PART_IDENT &&
                          wr_data == 16'hFFFF);
    end
  end
endmodule : core_reset_and_supply_monitor

// *** test/supply_mon_asserts.sv ***
`timescale 1ns/1ps
// ============================================================================
// Reset and supply checker on the monitor's ports
module supply_mon_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic core_supply_low,
  input wire logic main_ov_cmp,
  input wire logic gate_shutdown_cmp,
  input wire logic main_uv_cmp,
  input wire logic spi_miso,
  input wire logic reference_stable,
  input wire logic core_regulator_en,
  input wire logic power_on_reset_n,
  input wire logic core_reset_n,
  input wire logic main_load_connect,
  input wire logic gate_regulator_en,
  input wire logic predriver_enable,
  input wire logic main_supply_undervoltage
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  // ==========================================================================
  // Properties
  property p_reg_on;
    core_regulator_en |-> reference_stable;
  endproperty
  a_reg_on: assert property (p_reg_on) else $error("regulator ran early");
  property p_por;
    core_supply_low [*8] |-> ##[0:22] !power_on_reset_n;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset late");
  property p_and;
    $fell(power_on_reset_n) |-> ##[0:4] !core_reset_n;
  endproperty
  a_and: assert property (p_and) else $error("core reset missed");
  property p_quiet;
    !core_reset_n [*4] |-> !spi_miso;
  endproperty
  a_quiet: assert property (p_quiet) else $error("serial out in reset");
  property p_ov;
    main_ov_cmp [*2] |-> ##[0:19] !main_load_connect;
  endproperty
  a_ov: assert property (p_ov) else $error("load not cut");
  property p_gate;
    gate_shutdown_cmp [*2] |-> ##[0:19] !gate_regulator_en;
  endproperty
  a_gate: assert property (p_gate) else $error("gate regulator on");
  property p_pre;
    main_supply_undervoltage |-> !predriver_enable;
  endproperty
  a_pre: assert property (p_pre) else $error("driver on in low supply");
  // Comparator must have been high 16 clocks before the indication rose
  property p_filt;
    $rose(main_supply_undervoltage) |-> $past(main_uv_cmp, 16);
  endproperty
  a_filt: assert property (p_filt) else $error("glitch passed");
endmodule : supply_mon_asserts

// *** test/spi_host_model.sv ***
`timescale 1ns/1ps
// ============================================================================
// Host: mode 0 frames, clock idles low
module spi_host_model (
  input  wire logic miso,
  output logic      sck,
  output logic      cs_n,
  output logic      mosi
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // MISO taken late in the high phase, since it turns 3-4 clocks after a fall
  task automatic frame(input logic [31:0] tx, output logic [31:0] rx);
    cs_n = 1'b0;
    #413;
    for (int i = 31; i >= 0; i--) begin
      mosi = tx[i];
      #200 sck = 1'b1;
      #190 rx[i] = miso;
      #10 sck = 1'b0;
    end
    #200 cs_n = 1'b1;
    mosi = ~mosi;  // Released line holds no stale bit
    #400;
  endtask : frame
endmodule : spi_host_model

// *** test/core_reset_and_supply_monitor_tb_top.sv ***
`timescale 1ns/1ps
// ============================================================================
// Bench
module core_reset_and_supply_monitor_tb_top
  import supply_mon_pkg::*;
();
  logic clock, rst, bandgap_settled, core_supply_low, reset_pin_n, main_ov_cmp;
  logic gate_shutdown_cmp, main_uv_cmp, gate_supply_undervoltage, spi_sck, spi_cs_n;
  logic spi_mosi, spi_miso, spi_miso_oe, reference_stable, core_regulator_en;
  logic power_on_reset_n, core_reset_n, main_load_connect, gate_regulator_en;
  logic predriver_enable, main_supply_undervoltage, irq_n;
  logic [31:0] rx;
  int n_errors = 0;
  int n_compared = 0;
  core_reset_and_supply_monitor #(.REF_CYC(8)) uut (.clock, .rst, .bandgap_settled,
    .core_supply_low, .reset_pin_n, .main_ov_cmp, .gate_shutdown_cmp, .main_uv_cmp,
    .gate_supply_undervoltage, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe,
    .reference_stable, .core_regulator_en, .power_on_reset_n, .core_reset_n,
    .main_load_connect, .gate_regulator_en, .predriver_enable,
    .main_supply_undervoltage, .irq_n);
  spi_host_model u_host (.miso(spi_miso), .sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi));
  // ==========================================================================
  // Tasks
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : step
  // Frames end off the clock grid, so realign before the next input change
  task automatic rd(input logic [9:0] a);
    u_host.frame({6'h20, a, 16'h0000}, rx);
    step(1);
  endtask : rd
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    u_host.frame({6'h00, a, d}, rx);
    step(1);
  endtask : wr
  task automatic wait_core(input logic want);
    int i;
    for (i = 0; i < 400 && core_reset_n !== want; i++) step(1);
    if (i == 400) begin
      check("core reset wait", 32'(core_reset_n), 32'(want));
      complete_run();
    end
  endtask : wait_core
  task automatic chk1(input string what, input logic seen, input logic exp);
    check(what, 32'(seen), 32'(exp));
  endtask : chk1
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========================================================================
  // Sequence
  initial begin
    {rst, reset_pin_n, gate_supply_undervoltage} = 3'h7;
    {bandgap_settled, core_supply_low, main_ov_cmp, gate_shutdown_cmp, main_uv_cmp} = 5'h00;
    step(6);
    chk1("core in reset", core_reset_n, 1'b0);
    rst = 1'b0;
    step(40);
    chk1("regulator off", core_regulator_en, 1'b0);
    rd(ADDR_PART_IDENT);
    check("frame in reset", rx, 32'h0);
    bandgap_settled = 1'b1;
    step(7);
    chk1("reference early", reference_stable, 1'b0);
    wait_core(1'b1);
    chk1("regulator on", core_regulator_en, 1'b1);
    rd(ADDR_PART_IDENT);
    check("ident", rx, {CTRL_PATTERN, 8'h00, PART_IDENT_VALUE});
    chk1("miso released", spi_miso_oe, 1'b0);
    chk1("gate uv drivers", predriver_enable, 1'b0);
    gate_supply_undervoltage = 1'b0;
    step(8);
    chk1("drivers on", predriver_enable, 1'b1);
    rd(10'h3FF);
    check("unmapped", rx, {CTRL_PATTERN, 24'h0});
    $display("test start done");
    wr(ADDR_IRQ_CONFIG, 16'h0001);
    main_uv_cmp = 1'b1;
    step(40);
    chk1("uv filtered", main_supply_undervoltage, 1'b1);
    chk1("uv drivers", predriver_enable, 1'b0);
    chk1("irq", irq_n, 1'b0);
    wr(ADDR_IRQ_CONFIG, 16'h0000);
    chk1("irq masked", irq_n, 1'b1);
    main_uv_cmp = 1'b0;
    step(40);
    rd(ADDR_HEALTH_FLAGS);
    chk1("uv flag", rx[BIT_UV_MAIN], 1'b1);
    rd(ADDR_HEALTH_FLAGS);
    chk1("flag cleared", rx[BIT_UV_MAIN], 1'b0);
    $display("test undervoltage done");
    {main_ov_cmp, gate_shutdown_cmp} = 2'h3;
    step(20);
    chk1("load off", main_load_connect, 1'b0);
    chk1("gate reg off", gate_regulator_en, 1'b0);
    {main_ov_cmp, gate_shutdown_cmp} = 2'h0;
    step(20);
    chk1("load on", main_load_connect, 1'b1);
    chk1("gate reg on", gate_regulator_en, 1'b1);
    rd(ADDR_HEALTH_FLAGS);
    check("ov flags", rx, {CTRL_PATTERN, 8'h00, 16'h0006});
    $display("test overvoltage done");
    // Short dip below 361 ns must be ignored
    core_supply_low = 1'b1;
    step(5);
    core_supply_low = 1'b0;
    step(20);
    chk1("por glitch", power_on_reset_n, 1'b1);
    core_supply_low = 1'b1;
    step(30);
    chk1("por", power_on_reset_n, 1'b0);
    chk1("por core", core_reset_n, 1'b0);
    core_supply_low = 1'b0;
    wait_core(1'b1);
    reset_pin_n = 1'b0;
    step(8);
    chk1("pin reset", core_reset_n, 1'b0);
    rd(ADDR_PART_IDENT);
    check("frame pin reset", rx, 32'h0);
    reset_pin_n = 1'b1;
    wait_core(1'b1);
    wr(ADDR_IRQ_CONFIG, 16'h0007);
    wr(ADDR_PART_IDENT, 16'hFFFF);
    step(10);
    wait_core(1'b1);
    rd(ADDR_IRQ_CONFIG);
    check("soft reset", rx, {CTRL_PATTERN, 24'h0});
    $display("test resets done");
    complete_run();
  end
endmodule : core_reset_and_supply_monitor_tb_top

bind core_reset_and_supply_monitor supply_mon_asserts u_chk (.clock, .rst, .core_supply_low,
  .main_ov_cmp, .gate_shutdown_cmp, .main_uv_cmp, .spi_miso, .reference_stable,
  .core_regulator_en, .power_on_reset_n, .core_reset_n, .main_load_connect,
  .gate_regulator_en, .predriver_enable, .main_supply_undervoltage);
